// ### dv/safl_host_model.sv
// Host model: one register strobe at a time.
// Assumes a running core_clk and reset released before use.
`timescale 1ns/1ps
`default_nettype none
module safl_host_model (
	// Clock
	input wire logic core_clk,
	// Register port
	output logic [4:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ### dv/safl_top_asserts.sv
// Checker on the safl_top ports.
// Assumes binding to every safl_top instance.
`timescale 1ns/1ps
`default_nettype none
module safl_top_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Receive stream
	input wire logic rx_sof,
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	input wire logic rx_eof,
	input wire logic rx_err,
	input wire logic rx_buf_avail,
	input wire logic rx_page_upd,
	input wire logic [7:0] rx_page_val,
	// Results
	input wire logic rx_addr_hit,
	input wire logic rx_accept,
	input wire logic rx_reject,
	input wire logic rx_dest_mcast,
	input wire logic rx_ptr_restore,
	input wire logic [7:0] rx_write_page,
	input wire logic irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_tally_clear: assert property ((reg_rd && reg_addr == 5'h0f) ##2 (reg_rd && reg_addr == 5'h0f)
		|=> reg_rdata <= 8'h02) else $error("tally not cleared");
	a_station_readback: assert property (reg_rd && reg_addr >= 5'h11 && reg_addr <= 5'h16 && !$past(reg_wr)
		&& $past(reg_wr, 2) && $past(reg_addr, 2) == reg_addr |=> reg_rdata == $past(reg_wdata, 3))
		else $error("station byte readback");
	a_page_load: assert property (rx_page_upd |=> rx_write_page == $past(rx_page_val))
		else $error("page load");
	a_restore_cause: assert property (rx_ptr_restore |-> $past(rx_eof && rx_err))
		else $error("restore without error");
	a_hit_not_reject: assert property (rx_addr_hit |-> !rx_reject)
		else $error("hit and reject");
	a_accept_hit: assert property (rx_accept |-> rx_addr_hit && $past(rx_buf_avail))
		else $error("accept without hit");
	a_decide_bit: assert property ((rx_addr_hit || rx_reject) |-> $past(rx_bit_valid))
		else $error("decision not after bit");
	a_mcast_hold: assert property (!(rx_addr_hit || rx_reject) |-> $stable(rx_dest_mcast))
		else $error("mcast moved");
	cover property (rx_accept);
	cover property (rx_addr_hit && !rx_accept);
	cover property (rx_ptr_restore);
endmodule
bind safl_top safl_top_asserts i_chk (.*);
`default_nettype wire

// ### dv/safl_top_tb.sv
// Testbench: registers, random and corner frames, irq, monitor mode.
// Assumes safl_host_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module safl_top_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic rx_sof = 1'b0, rx_bit = 1'b0, rx_bit_valid = 1'b0, rx_eof = 1'b0, rx_err = 1'b0;
	logic rx_buf_avail = 1'b0, rx_page_upd = 1'b0, mon = 1'b0;
	logic [7:0] rx_page_val = 8'h00, rdv, exp_tally = 8'h00;
	logic [47:0] sta = 48'h0;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rx_write_page;
	logic reg_wr, reg_rd, rx_addr_hit, rx_accept, rx_reject, rx_dest_mcast, rx_ptr_restore, irq;
	int n_errors = 0, total_checks = 0;
	always #12.5 core_clk = ~core_clk;
	safl_host_model i_safl_host (.*);
	safl_top i_safl_top (.*);
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rchk(input logic [4:0] a, input logic [7:0] e);
		i_safl_host.rd(a, rdv);
		chk($sformatf("reg %h", a), e, rdv);
	endtask
	function logic [47:0] rnd_da();
		return ($urandom % 2) ? sta : sta ^ (48'h1 << ($urandom % 48));
	endfunction
	function logic counts(input logic hit, input logic bav, input logic m);
		return m ? hit : (hit && !bav);
	endfunction
	task frame(input logic [47:0] da, input logic bav, input logic err);
		logic hit;
		hit = (da == sta);
		@(posedge core_clk);
		rx_sof <= 1'b1;
		rx_buf_avail <= bav;
		for (int i = 0; i < 48; i++) begin
			@(posedge core_clk);
			rx_sof <= 1'b0;
			if ($urandom % 4 == 0) begin
				rx_bit_valid <= 1'b0;
				@(posedge core_clk);
			end
			rx_bit <= da[i];
			rx_bit_valid <= 1'b1;
		end
		@(posedge core_clk);
		rx_bit_valid <= 1'b0;
		rx_eof <= 1'b1;
		rx_err <= err;
		#1 chk("hit", hit, rx_addr_hit);
		chk("reject", !hit, rx_reject);
		chk("accept", hit && !mon && bav, rx_accept);
		chk("mcast", da[0], rx_dest_mcast);
		if (counts(hit, bav, mon))
			exp_tally++;
		@(posedge core_clk);
		rx_eof <= 1'b0;
		rx_err <= 1'b0;
		#1 chk("restore", err, rx_ptr_restore);
	endtask
	initial begin
		void'($urandom(32'h3e0a));
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 1; i < 7; i++)
			rchk(5'h10 + i[4:0], 8'h00);
		rchk(5'h17, 8'h4d);
		rchk(5'h0f, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			sta[8*i +: 8] = 8'($urandom);
			i_safl_host.wr(5'h11 + i[4:0], sta[8*i +: 8]);
			rchk(5'h11 + i[4:0], sta[8*i +: 8]);
		end
		rdv = 8'($urandom);
		i_safl_host.wr(5'h17, rdv);
		rchk(5'h17, rdv);
		i_safl_host.wr(5'h0f, 8'h5a);
		rchk(5'h0f, 8'h00);
		rchk(5'h1f, 8'h00);
		$display("test registers done");
		frame(sta ^ 48'h1, 1'b1, 1'b0);
		frame(sta ^ (48'h1 << 47), 1'b0, 1'b0);
		frame(sta, 1'b0, 1'b0);
		repeat (24)
			frame(rnd_da(), 1'($urandom), 1'b0);
		rchk(5'h0f, exp_tally);
		rchk(5'h0f, 8'h00);
		exp_tally = 8'h00;
		$display("test frames done");
		i_safl_host.wr(5'h19, 8'hff);
		i_safl_host.wr(5'h1a, 8'h01);
		rchk(5'h1a, 8'h01);
		frame(sta, 1'b1, 1'b0);
		chk("irq", 1'b1, irq);
		rchk(5'h19, 8'h01);
		i_safl_host.wr(5'h1a, 8'h00);
		#1 chk("irq masked", 1'b0, irq);
		i_safl_host.wr(5'h19, 8'h01);
		rchk(5'h19, 8'h00);
		$display("test irq done");
		// Buffer never available here, so any count comes from the monitor path
		i_safl_host.wr(5'h18, 8'h01);
		rchk(5'h18, 8'h01);
		mon = 1'b1;
		repeat (6)
			frame(rnd_da(), 1'b0, 1'b0);
		rchk(5'h0f, exp_tally);
		// 256 counted frames carry the tally through ff to 00 and raise the wrap flag
		exp_tally = 8'h00;
		repeat (256)
			frame(sta, 1'b0, 1'b0);
		rchk(5'h0f, exp_tally);
		rchk(5'h19, 8'h04);
		i_safl_host.wr(5'h18, 8'h00);
		mon = 1'b0;
		@(posedge core_clk);
		rx_page_val <= 8'($urandom);
		rx_page_upd <= 1'b1;
		@(posedge core_clk);
		rx_page_upd <= 1'b0;
		#1 chk("page", rx_page_val, rx_write_page);
		frame(sta, 1'b1, 1'b1);
		$display("test monitor and page done");
		tally_and_finish;
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ### rtl/safl_byte_cmp.v
// Byte-wise comparison of one received destination byte with a stored byte.
// Assumes the six stored bytes are presented flat, byte 0 in bits 7:0.
`timescale 1ns/1ps
`default_nettype none
`include "safl_defines.vh"

module safl_byte_cmp (
	// Received byte and its position in the destination field
	input wire [7:0] rx_byte,
	input wire [2:0] byte_idx,
	// Stored station address, byte n in bits 8n+7:8n
	input wire [47:0] sta_addr,
	// Result
	output wire byte_eq
);

	wire [`SAFL_BYTES-1:0] eq_vec;

	genvar gi;
	generate
		for (gi = 0; gi < `SAFL_BYTES; gi = gi + 1) begin : g_cmp
			localparam [31:0] IDX = gi;
			// Only the byte at the current position may answer
			assign eq_vec[gi] = (byte_idx == IDX[2:0]) && (rx_byte == sta_addr[8*gi+7:8*gi]); // [RULE5]
		end
	endgenerate

	assign byte_eq = |eq_vec;

endmodule
`default_nettype wire

// ### rtl/safl_defines.vh
// Constants for the station address filter and lost-frame tally.
// Assumes inclusion by bare name from the rtl files of this block.
`ifndef SAFL_DEFINES_VH
`define SAFL_DEFINES_VH

// Register address: bit 4 selects the page, bits 3:0 the offset
`define SAFL_ADDR_W 5
`define SAFL_PAGE_BIT 4
`define SAFL_PAGE0 1'b0
`define SAFL_PAGE1 1'b1

// Page 0
`define SAFL_OFS_LOST_TALLY 4'hf

// Page 1
`define SAFL_OFS_STA_BYTE0 4'h1
`define SAFL_OFS_STA_BYTE5 4'h6
`define SAFL_OFS_RX_PAGE 4'h7
`define SAFL_OFS_CTRL 4'h8
`define SAFL_OFS_IRQ_STAT 4'h9
`define SAFL_OFS_IRQ_MASK 4'ha

// Reset values
`define SAFL_RST_STA_BYTE 8'h00
`define SAFL_RST_RX_PAGE 8'h4d
`define SAFL_RST_TALLY 8'h00
`define SAFL_RST_CTRL 8'h00
`define SAFL_RST_IRQ 8'h00

// Control register fields
`define SAFL_CTRL_MONITOR 0

// Interrupt status and mask fields
`define SAFL_IRQ_ACCEPT 0
`define SAFL_IRQ_LOST 1
`define SAFL_IRQ_WRAP 2
`define SAFL_IRQ_RESTORE 3
`define SAFL_IRQ_USED 8'h0f

// Destination address layout
`define SAFL_DA_BITS 48
`define SAFL_DA_LAST_BIT 6'd47
`define SAFL_BYTES 6

`endif

// ### rtl/safl_top.v
// Station address filter with lost-frame tally and paged register access.
// Assumes a serial receive stream already stripped of preamble and sync,
// one bit per core_clk when rx_bit_valid is high, and a buffer manager beside it.
`timescale 1ns/1ps
`default_nettype none
`include "safl_defines.vh"

// Contract
// RULE1: Count a frame dropped for lack of buffer space in the 8-bit tally.
// RULE2: In monitor mode, count every frame that passes address recognition instead.
// RULE3: Tally is read-only at page 0 offset 0x0f, resetting to zero.
// RULE4: Compare each frame's destination with the station address to accept or reject.
// RULE5: Comparison runs one byte at a time against the matching stored byte.
// RULE6: Stored byte n bit k equals destination bit 8n+k.
// RULE7: Destination bits arrive bit 0 first, bit 47 last, before source bits.
// RULE8: Destination bit 0 marks physical versus multicast address.
// RULE9: Six station bytes are read/write at page 1 offsets 0x01-0x06, reset zero.
// RULE10: Receive write page is read/write at page 1 offset 0x07.
// RULE11: Receive write page names next reception's first buffer and restores pointers on error.
// RULE12: Host sets receive write page to ring start and leaves it alone afterwards.
// RULE13: Reading the tally clears it.
// RULE14: Physical match needs all six destination bytes equal to the stored bytes.
module safl_top (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Register port
	input wire [`SAFL_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Receive stream
	input wire rx_sof,
	input wire rx_bit,
	input wire rx_bit_valid,
	input wire rx_eof,
	input wire rx_err,
	input wire rx_buf_avail,
	// Buffer manager page update
	input wire rx_page_upd,
	input wire [7:0] rx_page_val,
	// Filter results
	output reg rx_addr_hit,
	output reg rx_accept,
	output reg rx_reject,
	output reg rx_dest_mcast,
	output reg rx_ptr_restore,
	output wire [7:0] rx_write_page,
	// Interrupt
	output wire irq
);

	localparam ST_IDLE = 2'd0;
	localparam ST_DEST = 2'd1;
	localparam ST_BODY = 2'd2;

	// Reset release through two flops
	reg rst_meta_b_r;
	reg rst_sync_b;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b_r <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b_r <= 1'b1;
			rst_sync_b <= rst_meta_b_r;
		end
	end

	// Registers
	reg [7:0] rx_page_r;
	reg [7:0] tally_r;
	reg [7:0] tally_nxt;
	reg [7:0] ctrl_r;
	reg [7:0] irq_stat_r;
	reg [7:0] irq_stat_nxt;
	reg [7:0] irq_mask_r;

	// Receive state
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [5:0] bit_cnt_r;
	reg [7:0] byte_sr_r;
	reg match_r;
	reg mcast_r;

	wire page_sel;
	wire [3:0] ofs;
	wire monitor;
	wire [7:0] rx_byte;
	wire byte_eq;
	wire last_bit;
	wire decide;
	wire hit_now;
	wire lost_now;
	wire count_now;
	wire tally_rd;
	wire [7:0] irq_ev;

	// Register decode and receive events
	wire [47:0] sta_addr;
	wire wr_pg1;
	wire rd_pg1;
	wire wr_rx_page;
	wire wr_ctrl;
	wire wr_irq_stat;
	wire wr_irq_mask;
	wire accept_now;
	wire reject_now;
	wire wrap_now;
	wire restore_now;
	reg [7:0] rdata_nxt;

	assign page_sel = reg_addr[`SAFL_PAGE_BIT];
	assign ofs = reg_addr[3:0];
	assign monitor = ctrl_r[`SAFL_CTRL_MONITOR];
	assign rx_write_page = rx_page_r;

	// One write select per register here, station bytes apart (byte_wr in g_sta); reads decode rd_pg1 or tally_rd and ofs in the read mux
	assign wr_pg1 = reg_wr && (page_sel == `SAFL_PAGE1);
	assign rd_pg1 = reg_rd && (page_sel == `SAFL_PAGE1);
	assign wr_rx_page = wr_pg1 && (ofs == `SAFL_OFS_RX_PAGE);
	assign wr_ctrl = wr_pg1 && (ofs == `SAFL_OFS_CTRL);
	assign wr_irq_stat = wr_pg1 && (ofs == `SAFL_OFS_IRQ_STAT);
	assign wr_irq_mask = wr_pg1 && (ofs == `SAFL_OFS_IRQ_MASK);

	// Incoming bit becomes the MSB; after eight bits bit 0 sits in the LSB
	assign rx_byte = {rx_bit, byte_sr_r[7:1]}; // [RULE6] [RULE7]
	assign last_bit = (bit_cnt_r == `SAFL_DA_LAST_BIT);
	assign decide = (state_r == ST_DEST) && rx_bit_valid && !rx_sof && last_bit;

	safl_byte_cmp u_cmp (
		.rx_byte(rx_byte),
		.byte_idx(bit_cnt_r[5:3]),
		.sta_addr(sta_addr),
		.byte_eq(byte_eq)
	);

	// All six bytes must match, including the last one being checked now
	assign hit_now = decide && match_r && byte_eq; // [RULE14] [RULE4]
	// Monitor mode never stores, so buffer space is irrelevant there
	assign lost_now = hit_now && !monitor && !rx_buf_avail; // [RULE1]
	assign count_now = monitor ? hit_now : lost_now; // [RULE2] [RULE1]
	assign tally_rd = reg_rd && (page_sel == `SAFL_PAGE0) && (ofs == `SAFL_OFS_LOST_TALLY);

	assign accept_now = hit_now && !monitor && rx_buf_avail; // [RULE4]
	assign reject_now = decide && !(match_r && byte_eq); // [RULE4]
	// A read in the same cycle restarts the tally at one, so that is no wrap
	assign wrap_now = count_now && (tally_r == 8'hff) && !tally_rd;
	assign restore_now = rx_eof && rx_err && (state_r == ST_BODY); // [RULE11]

	// Next state of the destination walk
	always @* begin
		state_nxt = state_r;
		if (rx_sof) begin
			// A new frame start abandons any frame still in progress
			state_nxt = ST_DEST;
		end else begin
			case (state_r)
				ST_DEST: begin
					if (rx_eof) begin
						state_nxt = ST_IDLE;
					end else if (rx_bit_valid && last_bit) begin
						state_nxt = ST_BODY;
					end
				end
				ST_BODY: begin
					if (rx_eof) begin
						state_nxt = ST_IDLE;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// Destination field walk
	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 6'd0;
			byte_sr_r <= 8'h00;
			match_r <= 1'b0;
			mcast_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (rx_sof) begin
				bit_cnt_r <= 6'd0;
				match_r <= 1'b1;
				mcast_r <= 1'b0;
			end else if ((state_r == ST_DEST) && !rx_eof && rx_bit_valid) begin
				byte_sr_r <= rx_byte;
				if (bit_cnt_r == 6'd0) begin
					mcast_r <= rx_bit; // [RULE8]
				end
				if (bit_cnt_r[2:0] == 3'd7) begin
					match_r <= match_r & byte_eq; // [RULE5]
				end
				if (!last_bit) begin
					bit_cnt_r <= bit_cnt_r + 6'd1;
				end
			end
		end
	end

	// Decision pulses, one cycle after the last destination bit; restore pulse one cycle after rx_eof
	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rx_addr_hit <= 1'b0;
			rx_accept <= 1'b0;
			rx_reject <= 1'b0;
			rx_ptr_restore <= 1'b0;
		end else begin
			rx_addr_hit <= hit_now;
			rx_accept <= accept_now; // [RULE4]
			rx_reject <= reject_now; // [RULE4]
			// Buffer manager rewinds to the saved page after a bad frame
			rx_ptr_restore <= restore_now; // [RULE11]
		end
	end

	// Multicast flag holds until the next frame reaches its decision
	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rx_dest_mcast <= 1'b0;
		end else if (decide) begin
			rx_dest_mcast <= mcast_r; // [RULE8]
		end
	end

	// Tally: a read clears it, but a count in the same cycle is kept
	always @* begin
		tally_nxt = tally_r;
		if (tally_rd) begin
			tally_nxt = 8'h00; // [RULE13]
		end
		if (count_now) begin
			tally_nxt = tally_rd ? 8'h01 : tally_r + 8'h01; // [RULE1] [RULE2]
		end
	end

	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			tally_r <= `SAFL_RST_TALLY; // [RULE3]
		end else begin
			tally_r <= tally_nxt;
		end
	end

	// Station address bytes, one register each so no vector has several drivers
	genvar gb;
	generate
		for (gb = 0; gb < `SAFL_BYTES; gb = gb + 1) begin : g_sta
			localparam [31:0] BYTE_OFS = `SAFL_OFS_STA_BYTE0 + gb;
			reg [7:0] byte_r;
			wire byte_wr;

			assign byte_wr = wr_pg1 && (ofs == BYTE_OFS[3:0]);

			always @(posedge core_clk or negedge rst_sync_b) begin
				if (!rst_sync_b) begin
					byte_r <= `SAFL_RST_STA_BYTE; // [RULE9]
				end else if (byte_wr) begin
					byte_r <= reg_wdata; // [RULE9]
				end
			end

			// Byte n lands at bits 8n+7:8n
			assign sta_addr[8*gb+7:8*gb] = byte_r; // [RULE6]
		end
	endgenerate

	// Receive write page: host sets it, the buffer manager advances it
	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rx_page_r <= `SAFL_RST_RX_PAGE;
		end else if (rx_page_upd) begin
			rx_page_r <= rx_page_val; // [RULE11]
		end else if (wr_rx_page) begin
			// Writing while frames flow moves the ring under the buffer manager
			rx_page_r <= reg_wdata; // [RULE10]
		end
	end

	// Control and interrupt mask
	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_r <= `SAFL_RST_CTRL;
			irq_mask_r <= `SAFL_RST_IRQ;
		end else begin
			if (wr_ctrl) begin
				// Only the monitor bit exists; the rest read back zero
				ctrl_r <= reg_wdata & 8'h01;
			end
			if (wr_irq_mask) begin
				irq_mask_r <= reg_wdata & `SAFL_IRQ_USED;
			end
		end
	end

	// Sticky events; a new event wins over a write-one-to-clear
	assign irq_ev = {4'h0, rx_ptr_restore, wrap_now, lost_now, accept_now};

	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (wr_irq_stat) begin
			irq_stat_nxt = irq_stat_r & ~reg_wdata;
		end
		irq_stat_nxt = irq_stat_nxt | irq_ev;
	end

	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_stat_r <= `SAFL_RST_IRQ;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Read data stands for the one cycle after the strobe; unmapped reads zero
	always @* begin
		rdata_nxt = 8'h00;
		if (tally_rd) begin
			rdata_nxt = tally_r; // [RULE3]
		end else if (rd_pg1 && ofs >= `SAFL_OFS_STA_BYTE0 && ofs <= `SAFL_OFS_STA_BYTE5) begin
			rdata_nxt = sta_addr[8*(ofs-4'h1) +: 8]; // [RULE9]
		end else if (rd_pg1 && ofs == `SAFL_OFS_RX_PAGE) begin
			rdata_nxt = rx_page_r; // [RULE10]
		end else if (rd_pg1 && ofs == `SAFL_OFS_CTRL) begin
			rdata_nxt = ctrl_r;
		end else if (rd_pg1 && ofs == `SAFL_OFS_IRQ_STAT) begin
			rdata_nxt = irq_stat_r;
		end else if (rd_pg1 && ofs == `SAFL_OFS_IRQ_MASK) begin
			rdata_nxt = irq_mask_r;
		end
	end

	always @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

endmodule
`default_nettype wire
